// ### core/fsr_host.sv
// Summary of operation
// - after that read, chip select stays high the minimum high time
// - bits 15:8 are junk; host masks them
// - bits 6..1 are meaningful only with bit 7 high
// - bit 0 may read either way; host masks it
// - after a suspend, host polls until bit 7 returns one
`timescale 1ns/10ps
`default_nettype none
module fsr_host
    import fsr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output fsr_pkg::fsr_pins_s pins,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_output
);
    import fsr_pkg::*;

    // ------------------------------------------------------------
    // pin access sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR = 3'b001,
        ST_WR_HI = 3'b010,
        ST_RD = 3'b011,
        ST_RD_HI = 3'b100
    } fsr_state_e;

    fsr_state_e state_q;
    logic [3:0] tmr_q;
    logic [15:0] dq_sync;
    logic rb_sync;
    logic [15:0] word_q;
    logic busy_q;
    logic poll_q;
    logic clr_q;
    logic rd_pend_q;
    logic [15:0] cnt_q;
    logic valid_q;
    logic done_q;
    logic start_go;
    logic start_clr;
    logic start_poll;

    fsr_sync #(.W(17)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({ready_busy_output, dq_in}),
        .q({rb_sync, dq_sync})
    );

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic ap_wr_q;
    logic ap_rd_q;
    logic [7:0] ap_addr_q;
    logic ap_take;

    assign ap_take = hsel && hready && htrans[1];
    assign start_go = ap_wr_q && ap_addr_q == FSR_CTRL_OFS && hwdata[FSR_CTRL_GO_BIT] && !busy_q;
    assign start_clr = ap_wr_q && ap_addr_q == FSR_CTRL_OFS && hwdata[FSR_CTRL_CLR_BIT]
        && !busy_q && !hwdata[FSR_CTRL_GO_BIT];
    assign start_poll = start_go && hwdata[FSR_CTRL_POLL_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_rd_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q <= ap_take && hwrite;
            ap_rd_q <= ap_take && !hwrite;
            ap_addr_q <= haddr[7:0];
        end
    end

    // read mux; zero for unmapped offsets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            unique case (haddr[7:0])
                FSR_STAT_OFS: hrdata <= {28'h0000000, rb_sync, valid_q, poll_q, busy_q};
                // upper byte and bit 0 masked; bits 6..1 only shown once ready
                FSR_WORD_OFS: hrdata <= {16'h0000, word_q[FSR_READY_BIT] ?
                    (word_q & FSR_VALID_MASK) : 16'h0000};
                FSR_CNT_OFS: hrdata <= {16'h0000, cnt_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // command and status read sequence
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
            poll_q <= 1'b0;
            clr_q <= 1'b0;
        end else if (start_go || start_clr) begin
            busy_q <= 1'b1;
            poll_q <= start_poll;
            clr_q <= start_clr;
        end else if (done_q) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            tmr_q <= 4'h0;
            pins <= FSR_PINS_IDLE;
            rd_pend_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (start_go || start_clr || rd_pend_q) begin
                        // status read command is one write cycle; the read follows it
                        state_q <= ST_WR;
                        tmr_q <= FSR_WE_LOW_CYC;
                        pins.ce_n <= 1'b0;
                        pins.we_n <= 1'b0;
                        pins.dq_oe <= 1'b1;
                        pins.addr <= FSR_CMD_ADDR;
                        pins.dq_out <= (start_clr || (rd_pend_q && clr_q)) ?
                            FSR_CMD_CLEAR : FSR_CMD_STATUS_READ;
                        rd_pend_q <= 1'b0;
                    end
                end
                ST_WR: begin
                    if (tmr_q == 4'h1) begin
                        state_q <= ST_WR_HI;
                        tmr_q <= FSR_HIGH_CYC;
                        pins <= FSR_PINS_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                ST_WR_HI: begin
                    if (tmr_q == 4'h1) begin
                        if (clr_q) begin
                            state_q <= ST_IDLE;
                            done_q <= 1'b1;
                        end else begin
                            // exactly one read access under the overlay
                            state_q <= ST_RD;
                            tmr_q <= FSR_ACCESS_CYC + 4'h2;
                            pins.ce_n <= 1'b0;
                            pins.oe_n <= 1'b0;
                            pins.addr <= FSR_CMD_ADDR;
                        end
                    end else begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                ST_RD: begin
                    if (tmr_q == 4'h1) begin
                        // hold both strobes high for the minimum high time
                        state_q <= ST_RD_HI;
                        tmr_q <= FSR_HIGH_CYC;
                        pins <= FSR_PINS_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                ST_RD_HI: begin
                    if (tmr_q == 4'h1) begin
                        state_q <= ST_IDLE;
                        // keep polling while busy after a suspend or operation
                        if (poll_q && !word_q[FSR_READY_BIT]) begin
                            rd_pend_q <= 1'b1;
                        end else begin
                            done_q <= 1'b1;
                        end
                    end else begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // captured status word and poll count
    // ------------------------------------------------------------
    // sampled two cycles after the data settle, covering synchroniser delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_q <= FSR_WORD_RST;
            valid_q <= 1'b0;
        end else if (start_go) begin
            valid_q <= 1'b0;
        end else if (state_q == ST_RD && tmr_q == 4'h1) begin
            word_q <= dq_sync;
            valid_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 16'h0000;
        end else if (start_go) begin
            cnt_q <= 16'h0000;
        end else if (state_q == ST_RD && tmr_q == 4'h1) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule : fsr_host
`default_nettype wire

// ### core/fsr_pkg.sv
package fsr_pkg;

    // ------------------------------------------------------------
    // host register map (AHB-Lite, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FSR_CTRL_OFS = 8'h00;
    localparam logic [7:0] FSR_STAT_OFS = 8'h04;
    localparam logic [7:0] FSR_WORD_OFS = 8'h08;
    localparam logic [7:0] FSR_CNT_OFS = 8'h0C;

    // control register fields
    localparam int FSR_CTRL_GO_BIT = 0;
    localparam int FSR_CTRL_CLR_BIT = 1;
    localparam int FSR_CTRL_POLL_BIT = 2;

    // ------------------------------------------------------------
    // device status word fields
    // ------------------------------------------------------------
    localparam int FSR_READY_BIT = 7;
    localparam int FSR_ESUSP_BIT = 6;
    localparam int FSR_EFAIL_BIT = 5;
    localparam int FSR_PFAIL_BIT = 4;
    localparam int FSR_ABORT_BIT = 3;
    localparam int FSR_PSUSP_BIT = 2;
    localparam int FSR_LOCK_BIT = 1;
    localparam logic [15:0] FSR_VALID_MASK = 16'h00FE;
    localparam logic [15:0] FSR_WORD_RST = 16'h0080;

    // device commands and addresses
    localparam logic [15:0] FSR_CMD_STATUS_READ = 16'h0070;
    localparam logic [15:0] FSR_CMD_CLEAR = 16'h0071;
    localparam logic [11:0] FSR_CMD_ADDR = 12'h555;

    // ------------------------------------------------------------
    // pin timing at 40 MHz (25 ns period)
    // ------------------------------------------------------------
    localparam int FSR_CLK_PS = 25000;
    localparam int FSR_ACCESS_NS = 70;
    localparam int FSR_WE_LOW_NS = 35;
    localparam int FSR_HIGH_NS = 35;
    localparam logic [3:0] FSR_ACCESS_CYC =
        4'((FSR_ACCESS_NS * 1000 + FSR_CLK_PS - 1) / FSR_CLK_PS);
    localparam logic [3:0] FSR_WE_LOW_CYC =
        4'((FSR_WE_LOW_NS * 1000 + FSR_CLK_PS - 1) / FSR_CLK_PS);
    localparam logic [3:0] FSR_HIGH_CYC =
        4'((FSR_HIGH_NS * 1000 + FSR_CLK_PS - 1) / FSR_CLK_PS);

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
        logic [11:0] addr;
        logic [15:0] dq_out;
    } fsr_pins_s;

    localparam fsr_pins_s FSR_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 12'h000, 16'h0000};

endpackage : fsr_pkg

// ### core/fsr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            q <= '0;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule : fsr_sync
`default_nettype wire

// ### tb/fsr_host_sva.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_host_sva
    import fsr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire fsr_pkg::fsr_pins_s pins
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // --------------------
    // pin and bus checks
    // --------------------
    wire logic rd_word = hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, FSR_WORD_OFS};
    a_okay_resp: assert property (!hresp && hreadyout) else $error("bad response");
    a_high_time: assert property ($rose(pins.ce_n) |-> pins.ce_n [*2])
        else $error("select high time too short");
    a_upper_mask: assert property (rd_word |=> hrdata[31:8] == 24'h0 && !hrdata[0])
        else $error("reserved bits not masked");
    a_busy_hide: assert property (rd_word |=> hrdata[7] || hrdata == 32'h0)
        else $error("busy status shown");
    a_oe_sel: assert property (!pins.oe_n |-> !pins.ce_n && !pins.dq_oe)
        else $error("read strobe without select or with drive");
    a_we_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n [*2] ##1 (pins.we_n && pins.ce_n))
        else $error("write pulse wrong length");
    a_cmd_addr: assert property (!pins.we_n |-> pins.dq_oe && pins.addr == FSR_CMD_ADDR)
        else $error("command write not driven at command address");
    c_word_read: cover property (rd_word);
    c_cmd_write: cover property ($fell(pins.we_n));
    c_dev_read: cover property ($fell(pins.oe_n));
endmodule : fsr_host_sva
`default_nettype wire

// ### tb/fsr_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_flash_model
    import fsr_pkg::*;
(
    input wire fsr_pkg::fsr_pins_s pins,
    input wire logic [15:0] dq,
    input wire logic rst_n,
    input wire logic ld,
    input wire logic [7:0] ld_val,
    output logic [15:0] dq_drv,
    output logic ready_busy_output
);
    logic [7:0] st = 8'h80;
    logic [7:0] junk = 8'h5A;
    logic ovl = 1'b0;
    wire logic rd_n = pins.ce_n | pins.oe_n;
    // --------------------
    // status word, overlay
    // --------------------
    // ld stands for an embedded algorithm starting (bit 7 low) or ending
    always @(negedge rst_n or posedge ld or negedge pins.we_n) begin
        if (!rst_n) st = 8'h80;
        else if (ld) st = ld_val;
        // command data taken from the pin struct itself: the resolved dq net settles later
        else if (!pins.ce_n && pins.dq_out == FSR_CMD_CLEAR && !ovl) st = st & 8'hC4;
    end
    always @(negedge rst_n or negedge pins.we_n or posedge rd_n) begin
        if (!rst_n) ovl = 1'b0;
        else if (!pins.we_n) begin
            if (!pins.ce_n && pins.dq_out == FSR_CMD_STATUS_READ) ovl = 1'b1;
        end else ovl = 1'b0;
    end
    // junk bits change every read so a host that forgets to mask is caught
    always @(negedge rd_n) junk = junk * 8'h25 + 8'h3B;
    always_comb begin
        if (rd_n) dq_drv = {~junk, junk};
        else if (ovl) dq_drv = {junk, st[7:1], junk[0]};
        else dq_drv = {4'hA, pins.addr};
    end
    assign ready_busy_output = st[7];
endmodule : fsr_flash_model
`default_nettype wire

// ### tb/fsr_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_host_tb;
    import fsr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    fsr_pins_s pins;
    logic [15:0] dq_in;
    logic [15:0] dq_drv;
    logic rb;
    logic dev_rst_n = 1'b0;
    logic ld = 1'b0;
    logic [7:0] ld_val = 8'h00;
    int mismatches = 0;
    int n_tests = 0;
    int ref_st = 'h80;
    int seed = 32'h1a0c46af;
    logic [31:0] rd;
    assign dq_in = pins.dq_oe ? pins.dq_out : dq_drv;
    fsr_host u_fsr_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .dq_in(dq_in),
        .ready_busy_output(rb));
    fsr_flash_model u_fsr_flash_model (.pins(pins), .dq(dq_in), .rst_n(dev_rst_n), .ld(ld),
        .ld_val(ld_val), .dq_drv(dq_drv), .ready_busy_output(rb));
    initial forever #12.5 hclk = ~hclk;
    // --------------------
    // bus and check tasks
    // --------------------
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic run(input logic [31:0] c);
        ahb(1'b1, FSR_CTRL_OFS, c);
        @(posedge hclk);
        rd = 32'h1;
        for (int i = 0; i < 400 && rd[0] !== 1'b0; i++) ahb(1'b0, FSR_STAT_OFS, 32'h0);
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask : run
    task automatic load(input logic [7:0] v);
        ld_val <= v;
        ld <= 1'b1;
        @(posedge hclk);
        ld <= 1'b0;
        ref_st = v;
    endtask : load
    task automatic word(input string nm);
        ahb(1'b0, FSR_WORD_OFS, 32'h0);
        chk(nm, ref_st[7] ? 32'(ref_st & 'hFE) : 32'h0, rd);
    endtask : word
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // --------------------
    // scenarios
    // --------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        dev_rst_n <= 1'b1;
        @(posedge hclk);
        run(32'h1);
        word("reset word");
        ahb(1'b0, FSR_CNT_OFS, 32'h0);
        chk("read count", 32'h1, rd);
        for (int i = 0; i < 8; i++) begin
            load(8'($random(seed)) | 8'h80);
            if (i[0]) begin
                run(32'h2);
                ref_st = ref_st & 'hC4;
            end
            // word register only moves on a status read, so fetch a fresh one
            run(32'h1);
            word("cleared word");
            run(32'h1);
            word("ready word");
        end
        load(8'h00);
        run(32'h1);
        word("busy word");
        fork
            run(32'h5);
            begin
                repeat (60) @(posedge hclk);
                load(8'hC4);
            end
        join
        word("polled word");
        ahb(1'b0, FSR_CNT_OFS, 32'h0);
        chk("polls", 32'h1, 32'(rd > 1));
        dev_rst_n <= 1'b0;
        @(posedge hclk);
        dev_rst_n <= 1'b1;
        ref_st = 'h80;
        run(32'h1);
        word("warm reset word");
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        ahb(1'b0, FSR_STAT_OFS, 32'h0);
        chk("stat after reset", 32'h8, rd);
        end_sim();
    end
    initial begin
        #2000000;
        mismatches++;
        end_sim();
    end
endmodule : fsr_host_tb
bind fsr_host fsr_host_sva u_fsr_host_sva (.*);
`default_nettype wire
